// [inc/fmac_consts.svh]
// Constants for the flash array mode and access control block.
// Assumes inclusion by bare name from the design file.
`ifndef FMAC_CONSTS_SVH
`define FMAC_CONSTS_SVH
// ******************************************
// Mode pin codes sampled while in reset.
// ******************************************
`define FMAC_PIN_ROM_OFF 3'h0
`define FMAC_PIN_USER 3'h1
`define FMAC_PIN_USER_BOOT 3'h2
`define FMAC_PIN_SERIAL_BOOT 3'h3
`define FMAC_PIN_PROGRAMMER 3'h4
// ******************************************
// Array extents and erase block layout.
// ******************************************
`define FMAC_BOOT_LIMIT 19'h02000
`define FMAC_UNIT_MASK 19'h0007f
`define FMAC_SMALL_BLOCKS 4'h8
`define FMAC_SIZE_SMALL 19'h01000
`define FMAC_SIZE_MID 19'h08000
`define FMAC_SIZE_BIG 19'h10000
`define FMAC_BASE_MID 19'h08000
// ******************************************
// Sequencing counts in clock cycles and the erase base reset value.
// ******************************************
`define FMAC_VEC_CHECK_CYCLES 4'h4
`define FMAC_AUTO_ERASE_CYCLES 8'h20
`define FMAC_RESET_VALUE_ADDR 19'h00000
`endif

// [inc/fmac_pkg.sv]
// Types shared by the flash access control block.
// Assumes nothing beyond a SystemVerilog compiler.
package fmac_pkg;
   // Operating modes of the device as seen by the flash.
   typedef enum logic [2:0] {
      FMAC_ROM_OFF,
      FMAC_USER,
      FMAC_USER_PROG,
      FMAC_USER_BOOT,
      FMAC_SERIAL_BOOT,
      FMAC_PROGRAMMER
   } fmac_mode_t;
   // Kinds of access a request may ask for.
   typedef enum logic [1:0] {
      FMAC_OP_READ,
      FMAC_OP_PROGRAM,
      FMAC_OP_ERASE
   } fmac_op_t;
   // The two memory arrays sharing one address space.
   typedef enum logic {
      FMAC_ARRAY_USER,
      FMAC_ARRAY_BOOT
   } fmac_array_t;
endpackage

// [design/fmac_access_ctrl.sv]
// Mode latch, array mapping and access gating for a two-array flash.
// Assumes synchronous inputs and a CPU that keeps its own obligations.
`timescale 1ns/1ns
`include "fmac_consts.svh"
module fmac_access_ctrl (
   // Clock, reset and clock enable.
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Mode pins and flash write enable pin.
   input wire logic [2:0] modePins,
   input wire logic flashWriteEnablePin,
   // Software control bits.
   input wire logic userProgramEnableBit,
   input wire logic softWriteEnable,
   input wire logic arraySelectWr,
   input wire fmac_pkg::fmac_array_t arraySelectData,
   // Access request from the CPU side.
   input wire logic reqValid,
   input wire fmac_pkg::fmac_op_t reqOp,
   input wire logic [18:0] reqAddr,
   input wire logic [3:0] eraseBlockNumber,
   input wire logic fetchFromRam,
   input wire logic programDone,
   // Serial receive line for bit rate detection.
   input wire logic serialRx,
   // Status and answers.
   output fmac_pkg::fmac_mode_t mode,
   output fmac_pkg::fmac_array_t array_select_register,
   output logic vectorFromEmbedded,
   output logic autoEraseBusy,
   output logic contentsHidden,
   output logic grant,
   output logic deny,
   output logic readUndefined,
   output logic [18:0] eraseBase,
   output logic [18:0] eraseSize,
   output logic [15:0] bitPeriod,
   output logic baudLocked
);
   // ******************************************
   // Mode latch.
   // ******************************************
   logic fweAtReset; // Enable pin level caught in reset.
   logic [3:0] vecCount; // Vector check countdown.
   logic [7:0] eraseCount; // Automatic erase countdown.
   logic [15:0] rxCount; // Low time of the first start bit.
   logic rxSeenLow; // A start bit is being timed.
   logic rdOk; // Read permitted now.
   logic wrOk; // Program or erase permitted now.
   logic next_grant; // Answer for the current request.

   // The pins are sampled in every reset cycle, so the last one wins.
   // Afterwards only the enable bit may move between the two user
   // modes; the pins are ignored so a glitch cannot change mode.
   always_ff @(posedge clk) begin
      if (rst) begin
         fweAtReset <= flashWriteEnablePin;
         unique case (modePins)
            `FMAC_PIN_USER: mode <= fmac_pkg::FMAC_USER;
            `FMAC_PIN_USER_BOOT: mode <= fmac_pkg::FMAC_USER_BOOT;
            `FMAC_PIN_SERIAL_BOOT: mode <= fmac_pkg::FMAC_SERIAL_BOOT;
            `FMAC_PIN_PROGRAMMER: mode <= fmac_pkg::FMAC_PROGRAMMER;
            default: mode <= fmac_pkg::FMAC_ROM_OFF;
         endcase
      end else if (ce) begin
         // Only user mode and user program mode swap, by the bit.
         if (mode == fmac_pkg::FMAC_USER &&
             userProgramEnableBit && fweAtReset) begin
            mode <= fmac_pkg::FMAC_USER_PROG;
         end else if (mode == fmac_pkg::FMAC_USER_PROG &&
                      !userProgramEnableBit) begin
            mode <= fmac_pkg::FMAC_USER;
         end
      end
   end

   // ******************************************
   // Array mapping and reset vector source.
   // ******************************************
   // User boot starts on the boot array; all else on the user array.
   // Select writes are held off while the vector is checked so the
   // embedded fetch cannot be redirected halfway.
   always_ff @(posedge clk) begin
      if (rst) begin
         if (modePins == `FMAC_PIN_USER_BOOT) begin
            array_select_register <= fmac_pkg::FMAC_ARRAY_BOOT;
         end else begin
            array_select_register <= fmac_pkg::FMAC_ARRAY_USER;
         end
      end else if (ce && arraySelectWr && !vectorFromEmbedded) begin
         array_select_register <= arraySelectData;
      end
   end

   // The embedded store serves the vector until the check is over.
   always_ff @(posedge clk) begin
      if (rst) begin
         vecCount <= `FMAC_VEC_CHECK_CYCLES;
         vectorFromEmbedded <= (modePins == `FMAC_PIN_USER_BOOT);
      end else if (ce && vectorFromEmbedded) begin
         vecCount <= vecCount - 4'h1;
         if (vecCount == 4'h1) begin
            vectorFromEmbedded <= 1'b0;
         end
      end
   end

   // ******************************************
   // Serial boot automatic erase.
   // ******************************************
   // Both arrays are wiped before anything else is allowed, and the
   // contents stay hidden until the first programming completes.
   always_ff @(posedge clk) begin
      if (rst) begin
         eraseCount <= `FMAC_AUTO_ERASE_CYCLES;
         autoEraseBusy <= (modePins == `FMAC_PIN_SERIAL_BOOT);
         contentsHidden <= (modePins == `FMAC_PIN_SERIAL_BOOT);
      end else if (ce) begin
         if (autoEraseBusy) begin
            eraseCount <= eraseCount - 8'h01;
            if (eraseCount == 8'h01) begin
               autoEraseBusy <= 1'b0;
            end
         end else if (programDone) begin
            contentsHidden <= 1'b0;
         end
      end
   end

   // ******************************************
   // Bit rate detection.
   // ******************************************
   // The first low pulse on the line is one start bit; its length in
   // clocks is the bit period. Only one measurement per reset.
   always_ff @(posedge clk) begin
      if (rst) begin
         rxCount <= 16'h0000;
         rxSeenLow <= 1'b0;
         bitPeriod <= 16'h0000;
         baudLocked <= 1'b0;
      end else if (ce && mode == fmac_pkg::FMAC_SERIAL_BOOT &&
                   !baudLocked) begin
         if (!serialRx) begin
            rxSeenLow <= 1'b1;
            // Saturate rather than wrap on a stuck-low line.
            if (rxCount != 16'hffff) begin
               rxCount <= rxCount + 16'h0001;
            end
         end else if (rxSeenLow) begin
            bitPeriod <= rxCount;
            baudLocked <= 1'b1;
         end
      end
   end

   // ******************************************
   // Permission decode.
   // ******************************************
   // Reads need ROM enabled and no erase or hidden state in progress.
   always_comb begin
      rdOk = (mode != fmac_pkg::FMAC_ROM_OFF);
      if (autoEraseBusy || contentsHidden) begin
         rdOk = 1'b0;
      end
   end

   // Writes need a writing mode, both protections open, the right
   // array, and on board a routine running out of RAM.
   always_comb begin
      wrOk = 1'b0;
      unique case (mode)
         fmac_pkg::FMAC_USER_PROG,
         fmac_pkg::FMAC_USER_BOOT: begin
            wrOk = (array_select_register ==
                    fmac_pkg::FMAC_ARRAY_USER);
         end
         fmac_pkg::FMAC_SERIAL_BOOT: wrOk = !autoEraseBusy;
         fmac_pkg::FMAC_PROGRAMMER: wrOk = 1'b1;
         fmac_pkg::FMAC_ROM_OFF,
         fmac_pkg::FMAC_USER: wrOk = 1'b0;
         default: wrOk = 1'b0;
      endcase
      if (!softWriteEnable || !flashWriteEnablePin) begin
         wrOk = 1'b0;
      end
      if (mode != fmac_pkg::FMAC_PROGRAMMER && !fetchFromRam) begin
         wrOk = 1'b0;
      end
   end

   // A program request must name the start of a 128-byte unit.
   always_comb begin
      unique case (reqOp)
         fmac_pkg::FMAC_OP_READ: next_grant = rdOk;
         fmac_pkg::FMAC_OP_PROGRAM: next_grant = wrOk &&
            ((reqAddr & `FMAC_UNIT_MASK) == 19'h00000);
         fmac_pkg::FMAC_OP_ERASE: next_grant = wrOk;
         default: next_grant = 1'b0;
      endcase
   end

   // ******************************************
   // Answers.
   // ******************************************
   // One answer pulse per request, one cycle after it.
   always_ff @(posedge clk) begin
      if (rst) begin
         grant <= 1'b0;
         deny <= 1'b0;
         readUndefined <= 1'b0;
      end else if (ce) begin
         grant <= reqValid && next_grant;
         deny <= reqValid && !next_grant;
         // The data is still returned but flagged as meaningless.
         readUndefined <= reqValid && next_grant &&
            reqOp == fmac_pkg::FMAC_OP_READ &&
            array_select_register == fmac_pkg::FMAC_ARRAY_BOOT &&
            reqAddr >= `FMAC_BOOT_LIMIT;
      end
   end

   // Erase block geometry: eight small, one mid, seven big blocks.
   always_ff @(posedge clk) begin
      if (rst) begin
         eraseBase <= `FMAC_RESET_VALUE_ADDR;
         eraseSize <= `FMAC_SIZE_SMALL;
      end else if (ce && reqValid && reqOp == fmac_pkg::FMAC_OP_ERASE) begin
         if (eraseBlockNumber < `FMAC_SMALL_BLOCKS) begin
            eraseBase <= {4'h0, eraseBlockNumber[2:0], 12'h000};
            eraseSize <= `FMAC_SIZE_SMALL;
         end else if (eraseBlockNumber == `FMAC_SMALL_BLOCKS) begin
            eraseBase <= `FMAC_BASE_MID;
            eraseSize <= `FMAC_SIZE_MID;
         end else begin
            eraseBase <= {eraseBlockNumber[2:0], 16'h0000};
            eraseSize <= `FMAC_SIZE_BIG;
         end
      end
   end

   // ******************************************
   // Assertions.
   // ******************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // A request that the block takes on this edge.
   sequence s_req_ce;
      reqValid && ce;
   endsequence
   // Four enabled edges in a row, as long as the vector check lasts.
   sequence s_vec_phase;
      ce [*4];
   endsequence
   property p_rom_off;
      s_req_ce and mode == fmac_pkg::FMAC_ROM_OFF |=> deny && !grant;
   endproperty
   a_rom_off: assert property (p_rom_off)
      else $error("Access granted with ROM disabled.");
   property p_user_nowrite;
      s_req_ce and mode == fmac_pkg::FMAC_USER &&
         reqOp != fmac_pkg::FMAC_OP_READ |=> deny;
   endproperty
   a_user_nowrite: assert property (p_user_nowrite)
      else $error("Write granted in plain user mode.");
   // A grant frozen by a low ce no longer belongs to the last request.
   property p_boot_write;
      grant && $past(ce) && $past(reqOp) != fmac_pkg::FMAC_OP_READ &&
         $past(array_select_register) == fmac_pkg::FMAC_ARRAY_BOOT
         |-> $past(mode) == fmac_pkg::FMAC_SERIAL_BOOT ||
             $past(mode) == fmac_pkg::FMAC_PROGRAMMER;
   endproperty
   a_boot_write: assert property (p_boot_write)
      else $error("Boot array written in a wrong mode.");
   property p_protect;
      s_req_ce and (!softWriteEnable || !flashWriteEnablePin) &&
         reqOp != fmac_pkg::FMAC_OP_READ |=> deny;
   endproperty
   a_protect: assert property (p_protect)
      else $error("Write granted while protected.");
   property p_unit;
      s_req_ce and reqOp == fmac_pkg::FMAC_OP_PROGRAM &&
         reqAddr[6:0] != 7'h00 |=> !grant;
   endproperty
   a_unit: assert property (p_unit)
      else $error("Unaligned program unit granted.");
   property p_mode_hold;
      ce && mode == fmac_pkg::FMAC_USER_BOOT |=>
         mode == fmac_pkg::FMAC_USER_BOOT;
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("Latched mode changed without reset.");
   // High on the first four enabled edges after release, low on the fifth.
   property p_vector;
      $fell(rst) && mode == fmac_pkg::FMAC_USER_BOOT ##0 s_vec_phase
         |-> vectorFromEmbedded && $past(vectorFromEmbedded, 3)
         ##1 !vectorFromEmbedded;
   endproperty
   a_vector: assert property (p_vector)
      else $error("Vector check phase has wrong length.");
   property p_erase_ends;
      $fell(rst) && autoEraseBusy |-> ##[1:40] !autoEraseBusy;
   endproperty
   a_erase_ends: assert property (p_erase_ends)
      else $error("Automatic erase did not finish.");
   property p_block;
      s_req_ce and reqOp == fmac_pkg::FMAC_OP_ERASE &&
         eraseBlockNumber == 4'hf |=>
         eraseBase == 19'h70000 && eraseSize == `FMAC_SIZE_BIG;
   endproperty
   a_block: assert property (p_block)
      else $error("Last erase block mapped wrongly.");
   property p_one_answer;
      !(grant && deny);
   endproperty
   a_one_answer: assert property (p_one_answer)
      else $error("Grant and deny together.");
endmodule

// [bench/fmac_cpu_model.sv]
// CPU core model that issues flash requests on behalf of the bench.
// Assumes the bench calls access() and samples answers at falling edges.
`timescale 1ns/1ns
module fmac_cpu_model (
   // Clock.
   input wire logic clk,
   // Answers from the flash control.
   input wire logic grant,
   input wire logic deny,
   input wire logic readUndefined,
   input wire fmac_pkg::fmac_array_t array_select_register,
   // Request lines towards the flash control.
   output fmac_pkg::fmac_op_t reqOp,
   output logic reqValid,
   output logic [18:0] reqAddr,
   output logic [3:0] eraseBlockNumber,
   output logic arraySelectWr,
   output fmac_pkg::fmac_array_t arraySelectData
);
   // ****************
   // Request driver
   // ****************
   // Idle address and block lines carry the inverse of the last value, so nothing stale passes.
   initial begin
      reqValid = 1'b0;
      reqOp = fmac_pkg::FMAC_OP_READ;
      reqAddr = 19'h00000;
      eraseBlockNumber = 4'h0;
      arraySelectWr = 1'b0;
      arraySelectData = fmac_pkg::FMAC_ARRAY_USER;
   end
   // One request; both arrays share addresses, so select the target first.
   task automatic access(input fmac_pkg::fmac_op_t op,
      input fmac_pkg::fmac_array_t arr, input logic [18:0] addr,
      input logic [3:0] blk, output logic g, output logic d, output logic u);
      @(negedge clk);
      if (array_select_register !== arr) begin
         arraySelectWr = 1'b1;
         arraySelectData = arr;
         @(negedge clk);
         arraySelectWr = 1'b0;
      end
      reqValid = 1'b1;
      reqOp = op;
      reqAddr = addr;
      eraseBlockNumber = blk;
      @(negedge clk);
      reqValid = 1'b0;
      reqAddr = ~addr;
      eraseBlockNumber = ~blk;
      g = grant;
      d = deny;
      u = readUndefined;
   endtask
endmodule

// [bench/fmac_access_ctrl_tb_top.sv]
// Self-checking bench for the flash array mode and access control.
// Assumes the package, header and partner model are compiled first.
`timescale 1ns/1ns
`include "fmac_consts.svh"
module fmac_access_ctrl_tb_top;
   // ****************
   // Signals
   // ****************
   logic clk, rst, ce, flashWriteEnablePin, userProgramEnableBit;
   logic softWriteEnable, fetchFromRam, programDone, serialRx;
   logic [2:0] modePins;
   logic reqValid, arraySelectWr, vectorFromEmbedded, autoEraseBusy;
   logic contentsHidden, grant, deny, readUndefined, baudLocked;
   logic [18:0] reqAddr, eraseBase, eraseSize;
   logic [3:0] eraseBlockNumber;
   logic [15:0] bitPeriod;
   fmac_pkg::fmac_op_t reqOp;
   fmac_pkg::fmac_array_t arraySelectData, array_select_register;
   fmac_pkg::fmac_mode_t mode;
   int n_errors = 0;
   int compares = 0;
   int cyc = 0;
   // The clock enable stays high except in the freeze scenario.
   fmac_access_ctrl uut (.clk(clk), .rst(rst), .ce(ce),
      .modePins(modePins), .flashWriteEnablePin(flashWriteEnablePin),
      .userProgramEnableBit(userProgramEnableBit),
      .softWriteEnable(softWriteEnable), .arraySelectWr(arraySelectWr),
      .arraySelectData(arraySelectData), .reqValid(reqValid),
      .reqOp(reqOp), .reqAddr(reqAddr), .eraseBlockNumber(eraseBlockNumber),
      .fetchFromRam(fetchFromRam), .programDone(programDone),
      .serialRx(serialRx), .mode(mode),
      .array_select_register(array_select_register),
      .vectorFromEmbedded(vectorFromEmbedded), .autoEraseBusy(autoEraseBusy),
      .contentsHidden(contentsHidden), .grant(grant), .deny(deny),
      .readUndefined(readUndefined), .eraseBase(eraseBase),
      .eraseSize(eraseSize), .bitPeriod(bitPeriod), .baudLocked(baudLocked));
   fmac_cpu_model cpu (.clk(clk), .grant(grant), .deny(deny),
      .readUndefined(readUndefined),
      .array_select_register(array_select_register), .reqOp(reqOp),
      .reqValid(reqValid), .reqAddr(reqAddr),
      .eraseBlockNumber(eraseBlockNumber), .arraySelectWr(arraySelectWr),
      .arraySelectData(arraySelectData));
   // ****************
   // Expectations
   // ****************
   // Mode entered from the latched pins and the enable bit.
   function automatic fmac_pkg::fmac_mode_t exp_mode(input logic [2:0] p,
      input logic up);
      case (p)
         `FMAC_PIN_USER: begin
            return up ? fmac_pkg::FMAC_USER_PROG : fmac_pkg::FMAC_USER;
         end
         `FMAC_PIN_USER_BOOT: return fmac_pkg::FMAC_USER_BOOT;
         `FMAC_PIN_SERIAL_BOOT: return fmac_pkg::FMAC_SERIAL_BOOT;
         `FMAC_PIN_PROGRAMMER: return fmac_pkg::FMAC_PROGRAMMER;
         default: return fmac_pkg::FMAC_ROM_OFF;
      endcase
   endfunction
   // Permission of one request in a settled mode.
   function automatic logic exp_grant(input fmac_pkg::fmac_mode_t m,
      input logic [1:0] op, input logic arr, input logic [18:0] a,
      input logic sw, input logic pin, input logic ram);
      logic pr;
      pr = m == fmac_pkg::FMAC_PROGRAMMER;
      if (m == fmac_pkg::FMAC_ROM_OFF) return 1'b0;
      if (op == 2'h0) return 1'b1;
      if (m == fmac_pkg::FMAC_USER) return 1'b0;
      if (arr && !pr && m != fmac_pkg::FMAC_SERIAL_BOOT) return 1'b0;
      if (!sw || !pin || (!ram && !pr)) return 1'b0;
      return op != 2'h1 || a[6:0] == 7'h00;
   endfunction
   // Erase block base: the sizes of all lower blocks added up.
   function automatic logic [18:0] exp_base(input logic [3:0] b);
      logic [18:0] s;
      s = 19'h00000;
      for (int i = 0; i < b; i++) s += exp_size(4'(i));
      return s;
   endfunction
   function automatic logic [18:0] exp_size(input logic [3:0] b);
      return b < 4'h8 ? 19'h01000 : (b == 4'h8 ? 19'h08000 : 19'h10000);
   endfunction
   // ****************
   // Checking
   // ****************
   task automatic check(input logic [18:0] seen, input logic [18:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (n_errors == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Reset into one mode, then random requests with corner cases mixed in.
   task automatic run_mode(input logic [2:0] code, input logic up);
      logic g, d, u, arr;
      logic [18:0] a;
      logic [1:0] op;
      logic [3:0] blk;
      int cnt;
      int n;
      fmac_pkg::fmac_mode_t m;
      rst = 1'b1;
      modePins = code;
      flashWriteEnablePin = 1'b1;
      userProgramEnableBit = 1'b0;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      m = exp_mode(code, 1'b0);
      check({16'h0, mode}, {16'h0, m});
      check({18'h0, array_select_register}, {18'h0, code == 3'h2});
      modePins = 3'($urandom);
      cnt = 0;
      repeat (40) begin
         if (code == 3'h2) cnt += vectorFromEmbedded === 1'b1;
         else cnt += autoEraseBusy === 1'b1;
         @(negedge clk);
      end
      if (code == 3'h2) check(cnt[18:0], `FMAC_VEC_CHECK_CYCLES);
      if (code == 3'h3) begin
         check(cnt[18:0], `FMAC_AUTO_ERASE_CYCLES);
         cpu.access(fmac_pkg::FMAC_OP_READ, fmac_pkg::FMAC_ARRAY_USER,
            19'h00000, 4'h0, g, d, u);
         check({17'h0, g, d}, 19'h00001);
         check({18'h0, contentsHidden}, 19'h00001);
         programDone = 1'b1;
         @(negedge clk);
         programDone = 1'b0;
         check({18'h0, contentsHidden}, 19'h00000);
         n = 5 + $urandom % 20;
         serialRx = 1'b0;
         repeat (n) @(negedge clk);
         serialRx = 1'b1;
         repeat (3) @(negedge clk);
         check({3'h0, bitPeriod}, n[18:0]);
         check({18'h0, baudLocked}, 19'h00001);
      end
      userProgramEnableBit = up;
      repeat (2) @(negedge clk);
      m = exp_mode(code, up);
      check({16'h0, mode}, {16'h0, m});
      repeat (24) begin
         op = 2'($urandom % 3);
         arr = 1'($urandom);
         blk = 4'($urandom);
         a = 19'($urandom);
         if ($urandom % 2) a[6:0] = 7'h00;
         softWriteEnable = ($urandom % 4) != 0;
         flashWriteEnablePin = ($urandom % 4) != 0;
         fetchFromRam = ($urandom % 4) != 0;
         cpu.access(fmac_pkg::fmac_op_t'(op), fmac_pkg::fmac_array_t'(arr),
            a, blk, g, d, u);
         n = exp_grant(m, op, arr, a, softWriteEnable, flashWriteEnablePin,
            fetchFromRam);
         check({17'h0, g, d},
            {17'h0, n[0], !n[0]});
         check({18'h0, u}, {18'h0, n[0] && arr && op == 2'h0
            && a >= `FMAC_BOOT_LIMIT});
         if (op == 2'h2) begin
            check(eraseBase, exp_base(blk));
            check(eraseSize, exp_size(blk));
         end
      end
      if (up) begin
         // A frozen block must not follow the enable bit until ce returns.
         ce = 1'b0;
         userProgramEnableBit = 1'b0;
         repeat (2) @(negedge clk);
         check({16'h0, mode}, {16'h0, m});
         ce = 1'b1;
         repeat (2) @(negedge clk);
         check({16'h0, mode}, {16'h0, fmac_pkg::FMAC_USER});
      end
   endtask
   // ****************
   // Clock, timeout and main sequence
   // ****************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // The run needs under 1000 cycles; a hang is cut well beyond that.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      modePins = 3'h0;
      flashWriteEnablePin = 1'b1;
      userProgramEnableBit = 1'b0;
      softWriteEnable = 1'b1;
      fetchFromRam = 1'b1;
      programDone = 1'b0;
      serialRx = 1'b1;
      void'($urandom(21154));
      run_mode(3'h1, 1'b0);
      run_mode(3'h1, 1'b1);
      run_mode(3'h0, 1'b0);
      run_mode(3'h7, 1'b0);
      run_mode(3'h2, 1'b0);
      run_mode(3'h3, 1'b0);
      run_mode(3'h4, 1'b0);
      tally_and_finish();
   end
endmodule
